// File: core/flash_dev.sv
/*
 * flash device end: bank register, 3/4-byte address decode, status register 1,
 * soft reset and discovery table reads over a mode 0 spi link.
 * assumes the link pins are asynchronous to clk and sck is at most clk/8;
 * the array itself lives outside and answers rd_data the cycle after the strobe.
 */
`timescale 1ns/1ps
module flash_dev
    import flash_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    spi_link_if.device       link,
    output logic             addr_strobe,
    output logic [31:0]      rd_addr,
    input  wire logic [7:0]  rd_data,
    output logic             four_byte_mode,
    output logic [7:0]       bank_value
);

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_OPC   = 3'b001,
        PH_ADDR  = 3'b011,
        PH_DUMMY = 3'b010,
        PH_XFER  = 3'b110,
        PH_SKIP  = 3'b111
    } phase_e;

    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [2:0]  pin_f;
    logic [2:0]  pin_q;
    logic        cs_act;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic        cs_fall;
    phase_e      phase;
    logic [6:0]  rx_sh;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic [7:0]  rx_byte;
    logic [7:0]  opcode;
    logic [2:0]  addr_left;
    logic [31:0] addr_sh;
    logic [31:0] next_addr;
    logic [31:0] addr;
    logic        wr_taken;
    logic [7:0]  bank;
    logic [7:0]  status;
    logic [7:0]  tx_sh;
    logic        last_addr;
    logic        soft_rst;

    // three-stage pin synchroniser, a level counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= 3'b101;
            s2 <= 3'b101;
            s3 <= 3'b101;
            pin_f <= 3'b101;
            pin_q <= 3'b101;
        end else begin
            s1 <= {link.cs_n, link.sck, link.mosi};
            s2 <= s1;
            s3 <= s2;
            pin_f <= (pin_f & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
            pin_q <= pin_f;
        end
    end

    assign cs_act   = ~pin_f[2];
    assign sck_rise = cs_act & pin_f[1] & ~pin_q[1];
    assign sck_fall = cs_act & ~pin_f[1] & pin_q[1];
    assign cs_rise  = pin_f[2] & ~pin_q[2];
    assign cs_fall  = ~pin_f[2] & pin_q[2];
    assign byte_done = sck_rise && (bit_cnt == 3'd7);
    assign rx_byte   = {rx_sh, pin_f[0]};
    assign last_addr = (phase == PH_ADDR) && (addr_left == 3'd1);
    assign soft_rst  = cs_rise && (opcode == OP_SOFT_RST) && (phase == PH_SKIP);

    // effective address of the byte to fetch
    always_comb begin
        next_addr = addr + 32'd1;
        if (last_addr) begin
            next_addr = {addr_sh[23:0], rx_byte};
            if (opcode == OP_READ3 && !bank[BANK_MODE_BIT]) begin
                next_addr = {1'b0, bank[6:0], addr_sh[15:0], rx_byte};
            end
        end
    end

    // discovery table lookup
    function automatic logic [7:0] disc_byte(input logic [7:0] a);
        logic [7:0]  idx;
        logic [31:0] word;
        idx  = a - DISC_BASE;
        word = DISC_4B_WORD;
        if (idx[3:2] == 2'd1) begin
            word = DISC_MAP_HDR;
        end else if (idx[3:2] == 2'd2) begin
            word = DISC_MAP_RGN;
        end
        disc_byte = DISC_BLANK;
        if (a >= DISC_BASE && a <= DISC_LAST) begin
            disc_byte = word[{idx[1:0], 3'b000} +: 8];
        end
    endfunction : disc_byte

    // bit and byte framing
    always_ff @(posedge clk) begin
        if (rst || cs_fall || cs_rise) begin
            rx_sh   <= 7'h00;
            bit_cnt <= 3'd0;
        end else if (sck_rise) begin
            rx_sh   <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'd1;
        end
    end

    // command phase sequencing
    always_ff @(posedge clk) begin
        if (rst || cs_rise) begin
            phase     <= PH_IDLE;
            addr_left <= 3'd0;
            wr_taken  <= 1'b0;
            if (rst) begin
                opcode <= 8'h00;
            end
        end else if (cs_fall) begin
            phase    <= PH_OPC;
            wr_taken <= 1'b0;
        end else if (byte_done) begin
            unique case (phase)
                PH_OPC: begin
                    opcode <= rx_byte;
                    phase  <= PH_SKIP;
                    if (rx_byte == OP_RD_BANK || rx_byte == OP_WR_BANK) begin
                        phase <= PH_XFER;
                    end else if (rx_byte == OP_RD_SR || rx_byte == OP_WR_SR) begin
                        phase <= PH_XFER;
                    end else if (rx_byte == OP_READ3) begin
                        phase     <= PH_ADDR;
                        addr_left <= bank[BANK_MODE_BIT] ? ADDR_BYTES4 : ADDR_BYTES3;
                    end else if (rx_byte == OP_READ4) begin
                        phase     <= PH_ADDR;
                        addr_left <= ADDR_BYTES4;
                    end else if (rx_byte == OP_RD_DISC) begin
                        phase     <= PH_ADDR;
                        addr_left <= ADDR_BYTES3;
                    end
                end
                PH_ADDR: begin
                    addr_left <= addr_left - 3'd1;
                    if (addr_left == 3'd1) begin
                        phase <= (opcode == OP_RD_DISC) ? PH_DUMMY : PH_XFER;
                    end
                end
                PH_DUMMY: phase <= PH_XFER;
                PH_XFER:  wr_taken <= 1'b1;
                PH_IDLE:  phase <= PH_IDLE;
                PH_SKIP:  phase <= PH_SKIP;
            endcase
        end
    end

    // address shift, fetch address and array strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_sh     <= 32'h0;
            addr        <= 32'h0;
            addr_strobe <= 1'b0;
        end else begin
            addr_strobe <= 1'b0;
            if (byte_done && phase == PH_ADDR) begin
                addr_sh <= {addr_sh[23:0], rx_byte};
                if (last_addr) begin
                    addr        <= next_addr;
                    addr_strobe <= (opcode != OP_RD_DISC);
                end
            end else if (byte_done && phase == PH_XFER && opcode != OP_RD_DISC) begin
                addr        <= next_addr;
                addr_strobe <= (opcode == OP_READ3 || opcode == OP_READ4);
            end else if (byte_done && phase == PH_DUMMY) begin
                addr <= addr;
            end else if (byte_done && phase == PH_XFER) begin
                addr <= next_addr;
            end
        end
    end

    assign rd_addr = addr;

    // bank register, volatile
    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            bank <= BANK_RESET;
        end else if (byte_done && phase == PH_XFER && opcode == OP_WR_BANK && !wr_taken) begin
            bank <= rx_byte;
        end
    end

    assign four_byte_mode = bank[BANK_MODE_BIT];
    assign bank_value     = bank;

    // status register 1 and its write enable latch
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= SR_RESET;
        end else if (soft_rst) begin
            status[SR_WEL_BIT] <= 1'b0;
        end else if (cs_rise && opcode == OP_WR_EN && phase == PH_SKIP) begin
            status[SR_WEL_BIT] <= 1'b1;
        end else if (byte_done && phase == PH_XFER && opcode == OP_WR_SR && !wr_taken) begin
            if (status[SR_WEL_BIT]) begin
                status <= rx_byte & SR_WR_MASK;
            end
        end
    end

    // transmit shifter: load on byte end, shift on falls inside a byte
    always_ff @(posedge clk) begin
        if (rst || cs_fall) begin
            tx_sh <= 8'h00;
        end else if (byte_done) begin
            tx_sh <= 8'h00;
            if (phase == PH_OPC && rx_byte == OP_RD_BANK) begin
                tx_sh <= bank;
            end else if (phase == PH_OPC && rx_byte == OP_RD_SR) begin
                tx_sh <= status;
            end else if (phase == PH_XFER && opcode == OP_RD_BANK) begin
                tx_sh <= bank;
            end else if (phase == PH_XFER && opcode == OP_RD_SR) begin
                tx_sh <= status;
            end else if (phase == PH_DUMMY) begin
                tx_sh <= disc_byte(addr[7:0]);
            end else if (phase == PH_XFER && opcode == OP_RD_DISC) begin
                tx_sh <= disc_byte(next_addr[7:0]);
            end
        end else if (sck_fall && bit_cnt != 3'd0) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    // array data is taken the cycle after the strobe
    logic strobe_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= addr_strobe;
        end
    end

    logic [7:0] arr_byte;
    always_ff @(posedge clk) begin
        if (rst) begin
            arr_byte <= 8'h00;
        end else if (strobe_q) begin
            arr_byte <= rd_data;
        end
    end

    logic use_arr;
    always_ff @(posedge clk) begin
        if (rst || cs_rise || cs_fall) begin
            use_arr <= 1'b0;
        end else if (addr_strobe) begin
            use_arr <= 1'b1;
        end else if (byte_done) begin
            use_arr <= 1'b0;
        end
    end

    assign link.miso = use_arr && bit_cnt == 3'd0 && !strobe_q ? arr_byte[7] :
                       use_arr && bit_cnt != 3'd0 ? arr_byte[3'd7 - bit_cnt] : tx_sh[7];

endmodule : flash_dev

// File: inc/flash_pkg.sv
/*
 * shared constants for the serial flash address-mode block and its spi host:
 * opcodes, bank register layout, discovery table contents, host register map.
 * assumes single-bit spi mode 0 framing on both ends.
 */
package flash_pkg;

    // opcodes
    localparam logic [7:0] OP_RD_BANK   = 8'h16;
    localparam logic [7:0] OP_WR_BANK   = 8'h17;
    localparam logic [7:0] OP_SOFT_RST  = 8'hf0;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_SR     = 8'h01;
    localparam logic [7:0] OP_RD_SR     = 8'h05;
    localparam logic [7:0] OP_READ3     = 8'h03;
    localparam logic [7:0] OP_READ4     = 8'h13;
    localparam logic [7:0] OP_RD_DISC   = 8'h5a;
    localparam logic [7:0] OP_MODE_EXIT = 8'hff;

    // bank register layout
    localparam int         BANK_MODE_BIT = 7;
    localparam logic [7:0] BANK_RESET    = 8'h00;

    // status register 1 layout
    localparam int         SR_WEL_BIT = 1;
    localparam logic [7:0] SR_RESET   = 8'h00;
    localparam logic [7:0] SR_WR_MASK = 8'hfc;

    // address bytes per command
    localparam logic [2:0] ADDR_BYTES3 = 3'd3;
    localparam logic [2:0] ADDR_BYTES4 = 3'd4;

    // discovery table window
    localparam logic [7:0]  DISC_BASE     = 8'h3c;
    localparam logic [7:0]  DISC_LAST     = 8'h47;
    localparam logic [31:0] DISC_4B_WORD  = 32'ha8fa28f0;
    localparam logic [31:0] DISC_MAP_HDR  = 32'hff0000ff;
    localparam logic [31:0] DISC_MAP_RGN  = 32'h3ffffff4;
    localparam logic [7:0]  DISC_BLANK    = 8'hff;

    // host register map (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0c;

    // host ctrl fields
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_NTX_LSB = 8;
    localparam int CTRL_NRX_LSB = 12;
    localparam int CTRL_START   = 16;
    localparam int CTRL_EXIT    = 17;
    localparam int CTRL_WREN    = 18;
    localparam int STAT_BUSY    = 0;

    // host sck half period in clk cycles (4 -> 80 ns at 50 MHz)
    localparam int SCK_HALF_DEFAULT = 4;
    localparam int SCK_HALF_MIN     = 4;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

endpackage : flash_pkg

// File: inc/spi_link_if.sv
/*
 * single-bit spi link between the flash device end and the host end.
 * assumes the host drives cs_n, sck and mosi, the device drives miso.
 */
`timescale 1ns/1ps
interface spi_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;

    modport device (
        input  cs_n,
        input  sck,
        input  mosi,
        output miso
    );

    modport host (
        output cs_n,
        output sck,
        output mosi,
        input  miso
    );
endinterface : spi_link_if

// File: core/flash_host.sv
/*
 * spi host end: apb register front end that frames one flash command,
 * optionally preceded by a 0-4-4 exit frame and a write-enable frame.
 * assumes the device answers on miso within one sck period.
 */
`timescale 1ns/1ps
module flash_host
    import flash_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_DEFAULT
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    spi_link_if.host         link
);

    if (SCK_HALF < SCK_HALF_MIN || SCK_HALF > 255) begin : g_half_chk
        $error("flash_host: SCK_HALF out of range");
    end

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW  = 3'b001,
        H_HIGH = 3'b011,
        H_TAIL = 3'b010,
        H_GAP  = 3'b110
    } hstate_e;

    typedef enum logic [1:0] {
        K_EXIT = 2'd0,
        K_WREN = 2'd1,
        K_MAIN = 2'd2
    } kind_e;

    localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);

    hstate_e     state;
    kind_e       kind;
    logic [7:0]  op;
    logic [2:0]  n_tx;
    logic [2:0]  n_rx;
    logic [31:0] tx_data;
    logic [31:0] rx_data;
    logic        busy;
    logic        pend_exit;
    logic        pend_wren;
    logic [39:0] sh;
    logic [2:0]  bit_cnt;
    logic [3:0]  bytes_left;
    logic [7:0]  div;
    logic        half_done;
    logic [2:0]  ms;
    logic        miso_f;
    logic        wr_acc;
    logic        start_ok;
    logic        mapped;
    logic        rx_take;

    // miso returns a full sck period late through both synchronisers:
    // each bit is taken one rise later, the last one in the tail
    assign rx_take = kind == K_MAIN && (bytes_left < 4'(n_rx) || (bytes_left == 4'(n_rx) && bit_cnt != 3'd0));

    assign pready   = 1'b1;
    assign wr_acc   = psel && penable && pwrite;
    assign start_ok = wr_acc && paddr == REG_CTRL && pwdata[CTRL_START] && !busy;
    assign mapped   = paddr == REG_CTRL || paddr == REG_TXDATA || paddr == REG_STATUS || paddr == REG_RXDATA;
    assign pslverr  = psel && penable && !mapped;

    // apb read data, registered in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            unique case (paddr)
                REG_CTRL:   prdata <= {16'h0, 1'b0, n_rx, 1'b0, n_tx, op};
                REG_TXDATA: prdata <= tx_data;
                REG_STATUS: prdata <= {31'h0, busy};
                REG_RXDATA: prdata <= rx_data;
                default:    prdata <= 32'h0;
            endcase
        end
    end

    // command registers; writes are refused while a command runs
    always_ff @(posedge clk) begin
        if (rst) begin
            op      <= 8'h00;
            n_tx    <= 3'd0;
            n_rx    <= 3'd0;
            tx_data <= 32'h0;
        end else if (wr_acc && !busy) begin
            if (paddr == REG_CTRL) begin
                op   <= pwdata[CTRL_OP_LSB +: 8];
                n_tx <= pwdata[CTRL_NTX_LSB +: 3];
                n_rx <= pwdata[CTRL_NRX_LSB +: 3];
            end else if (paddr == REG_TXDATA) begin
                tx_data <= pwdata;
            end
        end
    end

    // miso synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            ms     <= 3'b000;
            miso_f <= 1'b0;
        end else begin
            ms <= {ms[1:0], link.miso};
            if (ms[1] == ms[2]) begin
                miso_f <= ms[2];
            end
        end
    end

    assign half_done = (div == HALF_M1);

    // frame engine and sck divider
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= H_IDLE;
            kind      <= K_MAIN;
            busy      <= 1'b0;
            pend_exit <= 1'b0;
            pend_wren <= 1'b0;
            sh        <= 40'h0;
            bit_cnt   <= 3'd0;
            bytes_left <= 4'd0;
            div       <= 8'h00;
            rx_data   <= 32'h0;
            link.cs_n <= 1'b1;
            link.sck  <= 1'b0;
        end else begin
            div <= half_done ? 8'h00 : div + 8'h01;
            unique case (state)
                H_IDLE: begin
                    div <= 8'h00;
                    if (start_ok) begin
                        busy      <= 1'b1;
                        pend_exit <= pwdata[CTRL_EXIT];
                        pend_wren <= pwdata[CTRL_WREN];
                        rx_data   <= 32'h0;
                    end else if (busy) begin
                        link.cs_n <= 1'b0;
                        bit_cnt   <= 3'd0;
                        state     <= H_LOW;
                        if (pend_exit) begin
                            kind       <= K_EXIT;
                            sh         <= {OP_MODE_EXIT, 32'h0};
                            bytes_left <= 4'd1;
                        end else if (pend_wren) begin
                            kind       <= K_WREN;
                            sh         <= {OP_WR_EN, 32'h0};
                            bytes_left <= 4'd1;
                        end else begin
                            kind       <= K_MAIN;
                            sh         <= {op, tx_data};
                            bytes_left <= 4'd1 + 4'(n_tx) + 4'(n_rx);
                        end
                    end
                end
                H_LOW: begin
                    if (half_done) begin
                        link.sck <= 1'b1;
                        state    <= H_HIGH;
                        if (rx_take) begin
                            rx_data <= {rx_data[30:0], miso_f};
                        end
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        link.sck <= 1'b0;
                        bit_cnt  <= bit_cnt + 3'd1;
                        state    <= H_LOW;
                        sh       <= {sh[38:0], 1'b0};
                        if (bit_cnt == 3'd7) begin
                            bytes_left <= bytes_left - 4'd1;
                            if (bytes_left == 4'd1) begin
                                state <= H_TAIL;
                            end
                        end
                    end
                end
                H_TAIL: begin
                    if (half_done) begin
                        link.cs_n <= 1'b1;
                        state     <= H_GAP;
                        if (kind == K_MAIN && n_rx != 3'd0) begin
                            rx_data <= {rx_data[30:0], miso_f};
                        end
                    end
                end
                H_GAP: begin
                    if (half_done) begin
                        state <= H_IDLE;
                        if (kind == K_EXIT) begin
                            pend_exit <= 1'b0;
                        end else if (kind == K_WREN) begin
                            pend_wren <= 1'b0;
                        end else begin
                            busy <= 1'b0;
                        end
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    assign link.mosi = sh[39];

endmodule : flash_host

// File: verif/flash_link_properties.sv
/* link checker: framing and timing seen on the shared spi link.
   assumes SCK_HALF of 4 clk and synchronous active high rst. */
`timescale 1ns/1ps
module flash_link_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso
);
    logic [2:0] bit_cnt;
    always_ff @(posedge clk) begin
        if (rst || cs_n)
            bit_cnt <= 3'h0;
        else if ($rose(sck))
            bit_cnt <= bit_cnt + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sck_idle_a: assert property (cs_n |-> !sck)
        else $error("sck moves outside a frame");
    sck_high_a: assert property ($rose(sck) |=> sck[*3] ##1 !sck)
        else $error("sck high phase not four cycles");
    sck_low_a: assert property ($fell(sck) && !cs_n |=> !sck[*3])
        else $error("sck low phase too short");
    cs_lead_a: assert property ($fell(cs_n) |-> !sck[*4] ##1 sck)
        else $error("first sck rise not half period after select");
    cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*4])
        else $error("gap between frames too short");
    mosi_hold_a: assert property ($rose(sck) |=> $stable(mosi)[*3])
        else $error("mosi changed while sck high");
    byte_frame_a: assert property ($rose(cs_n) |-> bit_cnt == 3'h0)
        else $error("frame not whole bytes");
    miso_hold_a: assert property ($rose(sck) |=> ##1 $stable(miso)[*2])
        else $error("miso changed near sampling edge");
    cover property ($rose(cs_n) ##4 $fell(cs_n));
    cover property ($rose(sck) && miso);
    cover property ($rose(cs_n));
endmodule : flash_link_properties

// File: verif/flash_address_mode_and_discovery_bench.sv
/* bench: host and device ends joined by one link, driven over apb.
   assumes pready answers, rd_data is given the cycle after addr_strobe. */
`timescale 1ns/1ps
module flash_address_mode_and_discovery_bench;
    import flash_pkg::*;
    typedef struct {logic [31:0] ctrl, tx, rx, mask; logic [7:0] bank;} row_s;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, rd_data = 8'h00, bank_value;
    logic [31:0] pwdata = 32'h0, prdata, rd_addr, q;
    logic        pready, pslverr, addr_strobe, four_byte_mode, e;
    int          errors = 0, cmp_count = 0;
    row_s        rows[15];
    spi_link_if  link ();
    always #10 clk = ~clk;
    flash_host u_flash_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    flash_dev u_flash_dev (.clk(clk), .rst(rst), .link(link), .addr_strobe(addr_strobe),
        .rd_addr(rd_addr), .rd_data(rd_data), .four_byte_mode(four_byte_mode), .bank_value(bank_value));
    flash_link_properties u_props (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sck(link.sck),
        .mosi(link.mosi), .miso(link.miso));
    always @(posedge clk) begin
        if (addr_strobe === 1'b1)
            rd_data <= rd_addr[7:0] ^ {1'b0, rd_addr[30:24]};
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        #1_200_000;
        errors++;
        end_sim();
    end
    initial begin
        rows = '{'{32'h00010117, 32'h05000000, 0, 0, 8'h05}, '{32'h00011016, 0, 32'h05, 32'hff, 8'h05},
            '{32'h00011303, 32'h12345600, 32'h53, 32'hff, 8'h05}, '{32'h00010117, 32'h85000000, 0, 0, 8'h85},
            '{32'h00011403, 32'h0a123456, 32'h5c, 32'hff, 8'h85}, '{32'h00011413, 32'h0b000011, 32'h1a, 32'hff, 8'h85},
            '{32'h000300f0, 0, 0, 0, 8'h00}, '{32'h00011413, 32'h03000020, 32'h23, 32'hff, 8'h00},
            '{32'h0001445a, 32'h00003c00, 32'hf028faa8, '1, 8'h00},
            '{32'h0001445a, 32'h00004000, 32'hff0000ff, '1, 8'h00},
            '{32'h0001445a, 32'h00004400, 32'hf4ffff3f, '1, 8'h00}, '{32'h00010101, 32'h04000000, 0, 0, 8'h00},
            '{32'h00011005, 0, 0, 32'hfc, 8'h00}, '{32'h00050101, 32'hfc000000, 0, 0, 8'h00},
            '{32'h00011005, 0, 32'hfc, 32'hfc, 8'h00}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        foreach (rows[i]) begin
            apb(1'b1, REG_TXDATA, rows[i].tx);
            apb(1'b1, REG_CTRL, rows[i].ctrl);
            for (int n = 0; n < 3000; n++) begin
                apb(1'b0, REG_STATUS, 32'h0);
                if (q[STAT_BUSY] === 1'b0)
                    break;
            end
            apb(1'b0, REG_RXDATA, 32'h0);
            chk("rxdata", rows[i].rx, q & rows[i].mask);
            chk("slverr", 32'h0, {31'h0, e});
            chk("bank", {24'h0, rows[i].bank}, {24'h0, bank_value});
            chk("mode", {31'h0, rows[i].bank[7]}, {31'h0, four_byte_mode});
            $display("row %0d done", i);
        end
        apb(1'b1, REG_TXDATA, 32'h85000000);
        apb(1'b1, REG_CTRL, 32'h00010117);
        repeat (400) @(posedge clk);
        chk("bank before reset", 32'h85, {24'h0, bank_value});
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("bank after reset", 32'h0, {24'h0, bank_value});
        chk("mode after reset", 32'h0, {31'h0, four_byte_mode});
        $display("reset test done");
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        $display("unmapped test done");
        end_sim();
    end
endmodule : flash_address_mode_and_discovery_bench
